//--- design/pwm_buffered_reload_ctrl.sv
// Buffered reload PWM with Wishbone registers and match flags
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
module pwm_buffered_reload_ctrl (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Sleep state
   input wire logic sleep,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Peer load events
   input wire logic [3:0] peer_load_evt,
   // Outputs
   output logic load_evt,
   output logic period_evt,
   output logic pwm_out,
   output logic irq
);
   logic [15:0] phase_buf_q, duty_buf_q, period_buf_q, offset_buf_q;
   logic [15:0] phase_op_q, duty_op_q, period_op_q, offset_op_q;
   logic ovr_buf_q, ovr_op_q;
   logic arm_q, mode_q;
   logic [1:0] src_q, clksel_q;
   logic [3:0] mask_q, flags;
   logic [15:0] timer_q;
   logic [3:0] peer_s1_q, peer_s2_q;
   pwm_reload_pkg::arm_state_e state_q;
   logic run, wr, rd_cyc, trig, arm_set, do_load, ack_q;
   logic [3:0] match, clr;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Waiting state entered by an arm write, from the mode bit written with it
   function automatic pwm_reload_pkg::arm_state_e arm_target(input logic trig_mode);
      arm_target = trig_mode ? pwm_reload_pkg::ARM_WAIT_TRIG
                             : pwm_reload_pkg::ARM_WAIT_PERIOD;
   endfunction

   // Clock continues in sleep only on internal oscillators
   assign run = ce && (!sleep || clksel_q == pwm_reload_pkg::CLK_FAST_OSC
                || clksel_q == pwm_reload_pkg::CLK_SLOW_OSC);

   assign rd_cyc = wb_cyc_i && wb_stb_i && !ack_q;
   // Writes land at the edge at which the master samples ack high
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   assign wb_ack_o = ack_q;

   // Bus handshake
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_q <= 1'b0;
      end
      else if (ce)
      begin
         ack_q <= rd_cyc;
      end
   end

   // Peer event synchronisers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         peer_s1_q <= 4'h0;
         peer_s2_q <= 4'h0;
      end
      else if (ce)
      begin
         peer_s1_q <= peer_load_evt;
         peer_s2_q <= peer_s1_q;
      end
   end

   assign trig = peer_s2_q[src_q];
   assign period_evt = run && (timer_q == period_op_q);

   // Software buffers; operating values untouched by writes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         phase_buf_q <= pwm_reload_pkg::RST_COUNT;
         duty_buf_q <= pwm_reload_pkg::RST_COUNT;
         period_buf_q <= pwm_reload_pkg::RST_PERIOD;
         offset_buf_q <= pwm_reload_pkg::RST_COUNT;
         ovr_buf_q <= 1'b0;
         mode_q <= 1'b0;
         src_q <= 2'h0;
         clksel_q <= pwm_reload_pkg::CLK_SYS;
         mask_q <= 4'h0;
      end
      else if (ce && wr)
      begin
         if (wb_adr_i == pwm_reload_pkg::ADDR_PHASE)
         begin
            phase_buf_q <= merge16(phase_buf_q, wb_dat_i, wb_sel_i);
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_DUTY)
         begin
            duty_buf_q <= merge16(duty_buf_q, wb_dat_i, wb_sel_i);
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_PERIOD)
         begin
            period_buf_q <= merge16(period_buf_q, wb_dat_i, wb_sel_i);
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_OFFSET)
         begin
            offset_buf_q <= merge16(offset_buf_q, wb_dat_i, wb_sel_i);
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_RELOAD)
         begin
            if (wb_sel_i[0])
            begin
               mode_q <= wb_dat_i[pwm_reload_pkg::BIT_MODE];
               src_q <= wb_dat_i[pwm_reload_pkg::BIT_SRC_LO +: 2];
            end
            if (wb_sel_i[1])
            begin
               ovr_buf_q <= wb_dat_i[pwm_reload_pkg::BIT_OVR];
            end
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_CLKSEL)
         begin
            if (wb_sel_i[0])
            begin
               clksel_q <= wb_dat_i[1:0];
            end
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_MASK)
         begin
            if (wb_sel_i[0])
            begin
               mask_q <= wb_dat_i[3:0];
            end
         end
      end
   end

   assign arm_set = ce && wr && wb_adr_i == pwm_reload_pkg::ADDR_RELOAD && wb_sel_i[0]
                    && wb_dat_i[pwm_reload_pkg::BIT_ARM];

   // Arm bit; hardware clear on load, new set wins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         arm_q <= 1'b0;
      end
      else if (ce)
      begin
         if (arm_set)
         begin
            arm_q <= 1'b1;
         end
         else if (do_load)
         begin
            arm_q <= 1'b0;
         end
      end
   end

   // Arming sequencer
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= pwm_reload_pkg::ARM_IDLE;
      end
      else if (ce)
      begin
         case (state_q)
            pwm_reload_pkg::ARM_IDLE:
            begin
               // Arming seen only next cycle, so a coincident period is skipped
               if (arm_set)
               begin
                  state_q <= arm_target(wb_dat_i[pwm_reload_pkg::BIT_MODE]);
               end
            end
            pwm_reload_pkg::ARM_WAIT_TRIG:
            begin
               if (!arm_q)
               begin
                  state_q <= pwm_reload_pkg::ARM_IDLE;
               end
               else if (trig)
               begin
                  state_q <= pwm_reload_pkg::ARM_WAIT_PERIOD;
               end
            end
            pwm_reload_pkg::ARM_WAIT_PERIOD:
            begin
               if (do_load && arm_set)
               begin
                  // Re-arm in the load cycle waits for a later period
                  state_q <= arm_target(wb_dat_i[pwm_reload_pkg::BIT_MODE]);
               end
               else if (do_load)
               begin
                  state_q <= pwm_reload_pkg::ARM_IDLE;
               end
            end
            default:
            begin
               state_q <= pwm_reload_pkg::ARM_IDLE;
            end
         endcase
      end
   end

   assign do_load = arm_q && state_q == pwm_reload_pkg::ARM_WAIT_PERIOD
                    && period_evt;
   assign load_evt = do_load;

   // Operating buffers, all loaded together
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         phase_op_q <= pwm_reload_pkg::RST_COUNT;
         duty_op_q <= pwm_reload_pkg::RST_COUNT;
         period_op_q <= pwm_reload_pkg::RST_PERIOD;
         offset_op_q <= pwm_reload_pkg::RST_COUNT;
         ovr_op_q <= 1'b0;
      end
      else if (ce && do_load)
      begin
         phase_op_q <= phase_buf_q;
         duty_op_q <= duty_buf_q;
         period_op_q <= period_buf_q;
         offset_op_q <= offset_buf_q;
         ovr_op_q <= ovr_buf_q;
      end
   end

   // Timer
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         timer_q <= pwm_reload_pkg::RST_COUNT;
      end
      else if (run)
      begin
         timer_q <= period_evt ? pwm_reload_pkg::RST_COUNT : timer_q + 16'h0001;
      end
   end

   assign match[pwm_reload_pkg::FLG_PHASE] = timer_q == phase_op_q;
   assign match[pwm_reload_pkg::FLG_DUTY] = timer_q == duty_op_q;
   assign match[pwm_reload_pkg::FLG_PERIOD] = timer_q == period_op_q;
   assign match[pwm_reload_pkg::FLG_OFFSET] = timer_q == offset_op_q;
   assign clr = (wr && wb_adr_i == pwm_reload_pkg::ADDR_STATUS && wb_sel_i[0])
                ? wb_dat_i[3:0] : 4'h0;

   // Clears act whenever enabled; match levels only move while running
   pwm_edge_flags u_flags (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .match(match),
      .clr(clr),
      .flags_q(flags)
   );

   assign irq = |(flags & mask_q);

   // Output level: high from phase until duty, forced by override
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pwm_out <= 1'b0;
      end
      else if (run)
      begin
         if (ovr_op_q)
         begin
            pwm_out <= 1'b1;
         end
         else if (match[pwm_reload_pkg::FLG_DUTY])
         begin
            pwm_out <= 1'b0;
         end
         else if (match[pwm_reload_pkg::FLG_PHASE])
         begin
            pwm_out <= 1'b1;
         end
      end
   end

   // Read data
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wb_dat_o <= 32'h00000000;
      end
      else if (ce && rd_cyc)
      begin
         if (wb_adr_i == pwm_reload_pkg::ADDR_PHASE)
         begin
            wb_dat_o <= {16'h0000, phase_buf_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_DUTY)
         begin
            wb_dat_o <= {16'h0000, duty_buf_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_PERIOD)
         begin
            wb_dat_o <= {16'h0000, period_buf_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_OFFSET)
         begin
            wb_dat_o <= {16'h0000, offset_buf_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_RELOAD)
         begin
            wb_dat_o <= {23'h0, ovr_buf_q, arm_q, mode_q, 4'h0, src_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_CLKSEL)
         begin
            wb_dat_o <= {30'h0, clksel_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_STATUS)
         begin
            wb_dat_o <= {28'h0, flags};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_MASK)
         begin
            wb_dat_o <= {28'h0, mask_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_TIMER)
         begin
            wb_dat_o <= {16'h0000, timer_q};
         end
         else if (wb_adr_i == pwm_reload_pkg::ADDR_OPER)
         begin
            wb_dat_o <= {period_op_q, duty_op_q};
         end
         else
         begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end
endmodule

//--- design/pwm_reload_pkg.sv
// Constants, register map and types for the buffered reload PWM block
// Summary of operation
// - Software values kept apart from operating values
// - Buffered writes act only after a load
// - Trigger-mode bit picks method; arm always required
// - All four pairs load in one cycle
// - Immediate mode loads at next period event
// - Triggered mode arms only after peer load
// - Two-bit source field picks the peer
// - Triggered load at period after trigger
// - Load clears the arm bit
// - Arm set at period match waits one period
// - Keeps running in sleep on internal oscillators
// - Four match flags: phase, duty, period, offset
// - Flags set on rising edge of match
package pwm_reload_pkg;
   localparam int unsigned CNT_W = 16;
   localparam logic [7:0] ADDR_PHASE = 8'h00;
   localparam logic [7:0] ADDR_DUTY = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;
   localparam logic [7:0] ADDR_OFFSET = 8'h0C;
   localparam logic [7:0] ADDR_RELOAD = 8'h10;
   localparam logic [7:0] ADDR_CLKSEL = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1C;
   localparam logic [7:0] ADDR_TIMER = 8'h20;
   localparam logic [7:0] ADDR_OPER = 8'h24;
   // Reload control fields
   localparam int unsigned BIT_ARM = 7;
   localparam int unsigned BIT_MODE = 6;
   localparam int unsigned BIT_SRC_LO = 0;
   localparam int unsigned BIT_OVR = 8;
   // Status fields
   localparam int unsigned FLG_PHASE = 0;
   localparam int unsigned FLG_DUTY = 1;
   localparam int unsigned FLG_PERIOD = 2;
   localparam int unsigned FLG_OFFSET = 3;
   // Clock source codes
   localparam logic [1:0] CLK_SYS = 2'h0;
   localparam logic [1:0] CLK_FAST_OSC = 2'h1;
   localparam logic [1:0] CLK_SLOW_OSC = 2'h2;
   localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
   localparam logic [CNT_W-1:0] RST_PERIOD = 16'hFFFF;
   typedef enum logic [1:0] {ARM_IDLE, ARM_WAIT_TRIG, ARM_WAIT_PERIOD} arm_state_e;
endpackage

//--- design/pwm_edge_flags.sv
// Rising-edge sticky flags with write-one-to-clear
module pwm_edge_flags (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Match levels and clear
   input wire logic [3:0] match,
   input wire logic [3:0] clr,
   // Flags
   output logic [3:0] flags_q
);
   logic [3:0] match_q;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         match_q <= 4'h0;
      end
      else if (ce)
      begin
         match_q <= match;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_flag
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               flags_q[i] <= 1'b0;
            end
            else if (ce)
            begin
               if (match[i] && !match_q[i])
               begin
                  flags_q[i] <= 1'b1;
               end
               else if (clr[i])
               begin
                  flags_q[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule

//--- verification/pwm_buffered_reload_ctrl_props.sv
// Checker for bus, reload and freeze timing of the buffered reload PWM block
module pwm_reload_props (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Events and outputs
   input wire logic load_evt,
   input wire logic period_evt,
   input wire logic pwm_out,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("no ack");
   property p_ack_pulse;
      wb_ack_o && ce |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_no_ack_idle;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_no_ack_idle: assert property (p_no_ack_idle) else $error("stray ack");
   property p_dat_change;
      $changed(wb_dat_o) |-> wb_ack_o;
   endproperty
   a_dat_change: assert property (p_dat_change) else $error("read data moved");
   property p_load_at_period;
      load_evt |-> period_evt && ce;
   endproperty
   a_load_at_period: assert property (p_load_at_period) else $error("load off period");
   property p_load_pulse;
      load_evt |=> !load_evt;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load too long");
   property p_freeze;
      !ce |=> $stable(pwm_out) && $stable(irq);
   endproperty
   a_freeze: assert property (p_freeze) else $error("moved while frozen");
   property p_no_ack_frozen;
      !ce && !wb_ack_o |=> !wb_ack_o;
   endproperty
   a_no_ack_frozen: assert property (p_no_ack_frozen) else $error("ack while frozen");
endmodule
bind pwm_buffered_reload_ctrl pwm_reload_props u_props (.clk(clk), .nrst(nrst), .ce(ce),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .load_evt(load_evt), .period_evt(period_evt), .pwm_out(pwm_out), .irq(irq));

//--- verification/peer_load_model.sv
// Peer PWM modules that answer a fire request with a one-cycle load pulse
module peer_load_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Fire requests and load pulses
   input wire logic [3:0] go,
   output logic [3:0] peer_load_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_q;
   logic [3:0] pend_q;
   // Stand-alone peers reload on their own period, so a request may wait up to 8 cycles
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q <= 3'h0;
         pend_q <= 4'h0;
         peer_load_evt <= 4'h0;
      end
      else
      begin
         cnt_q <= cnt_q + 3'h1;
         peer_load_evt <= (cnt_q == 3'h0) ? (pend_q | go) : 4'h0;
         pend_q <= (cnt_q == 3'h0) ? 4'h0 : (pend_q | go);
      end
   end
endmodule

//--- verification/tb_pwm_buffered_reload_ctrl.sv
// Self-checking bench for the buffered reload PWM block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
$display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_pwm_buffered_reload_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, sleep = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] go = 4'h0;
   logic [31:0] dat = 32'h0, q, dat_o, seed = 32'h43F857C4, duty;
   logic ack, load_evt, period_evt, pwm_out, irq;
   logic [3:0] peer;
   int err_count = 0, comparisons = 0, n, p1;
   pwm_buffered_reload_ctrl dut_u (.clk(clk), .nrst(nrst), .ce(ce), .sleep(sleep),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .peer_load_evt(peer),
      .load_evt(load_evt), .period_evt(period_evt), .pwm_out(pwm_out), .irq(irq));
   peer_load_model peer_u (.clk(clk), .nrst(nrst), .go(go), .peer_load_evt(peer));
   initial forever #4 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ack !== 1'b1 && k < 20);
      q = dat_o;
      if (k >= 20)
         err_count++;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic wait_sig(input bit which, input int lim);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while ((which ? period_evt : load_evt) !== 1'b1 && n < lim);
   endtask
   initial
   begin
      repeat (95000) @(posedge clk);
      err_count++;
      conclude();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      wb(1'b0, pwm_reload_pkg::ADDR_PERIOD, 32'h0);
      `CHK("period buffer", 32'h0000FFFF, q)
      wb(1'b1, 8'h30, 32'h1234);
      wb(1'b0, 8'h30, 32'h0);
      `CHK("unmapped", 32'h0, q)
      p1 = 16 + (rnd() & 15);
      wb(1'b1, pwm_reload_pkg::ADDR_PHASE, 32'h2);
      wb(1'b1, pwm_reload_pkg::ADDR_DUTY, 32'h8);
      wb(1'b1, pwm_reload_pkg::ADDR_PERIOD, 32'(p1));
      wb(1'b1, pwm_reload_pkg::ADDR_OFFSET, 32'h4);
      wb(1'b0, pwm_reload_pkg::ADDR_OPER, 32'h0);
      `CHK("operating before arm", 32'hFFFF0000, q)
      wb(1'b1, pwm_reload_pkg::ADDR_RELOAD, 32'h80);
      wb(1'b0, pwm_reload_pkg::ADDR_RELOAD, 32'h0);
      `CHK("arm", 32'h80, q & 32'h80)
      wait_sig(1'b0, 70000);
      `CHK("immediate load", 1'b1, load_evt)
      `CHK("load on period", 1'b1, period_evt)
      wb(1'b0, pwm_reload_pkg::ADDR_OPER, 32'h0);
      `CHK("operating after load", {p1[15:0], 16'h0008}, q)
      wb(1'b0, pwm_reload_pkg::ADDR_RELOAD, 32'h0);
      `CHK("arm cleared", 32'h0, q & 32'h80)
      wait_sig(1'b1, 100);
      wait_sig(1'b1, 100);
      `CHK("period spacing", p1 + 1, n)
      for (int s = 0; s < 4; s++)
      begin
         duty = rnd() & 32'hF;
         wb(1'b1, pwm_reload_pkg::ADDR_DUTY, duty);
         wb(1'b1, pwm_reload_pkg::ADDR_RELOAD, 32'hC0 | s);
         go <= 4'h1 << ((s + 1) % 4);
         @(posedge clk);
         go <= 4'h0;
         wait_sig(1'b0, 3 * p1 + 20);
         `CHK("other peer ignored", 1'b0, load_evt)
         go <= 4'h1 << s;
         @(posedge clk);
         go <= 4'h0;
         wait_sig(1'b0, 3 * p1 + 40);
         `CHK("triggered load", 1'b1, load_evt)
         `CHK("triggered on period", 1'b1, period_evt)
         wb(1'b0, pwm_reload_pkg::ADDR_OPER, 32'h0);
         `CHK("triggered duty", {p1[15:0], duty[15:0]}, q)
      end
      wb(1'b1, pwm_reload_pkg::ADDR_MASK, 32'hF);
      for (int k = 0; k < 3; k++)
      begin
         wb(1'b1, pwm_reload_pkg::ADDR_CLKSEL, 32'(k));
         sleep <= 1'b1;
         wb(1'b1, pwm_reload_pkg::ADDR_STATUS, 32'hF);
         repeat (2 * p1 + 4) @(negedge clk);
         wb(1'b0, pwm_reload_pkg::ADDR_STATUS, 32'h0);
         `CHK("flags in sleep", (k == 0) ? 32'h0 : 32'hF, q)
         @(negedge clk);
         `CHK("irq", k != 0, irq)
      end
      wb(1'b1, pwm_reload_pkg::ADDR_CLKSEL, 32'h0);
      sleep <= 1'b0;
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      wb(1'b1, pwm_reload_pkg::ADDR_RELOAD, 32'h180);
      wait_sig(1'b0, 3 * p1 + 10);
      repeat (3) @(negedge clk);
      `CHK("override level", 1'b1, pwm_out)
      conclude();
   end
endmodule
